/* File: verilog/fou_unpack.sv */
// fou_unpack: float entry decode, two-pass operand fetch and unpack
// assumes memory answers each read with a level reply pin and data pins,
// both asynchronous; instruction and branch test come from same-clock logic
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - branch test 37 sets control address bit 8
// - opcode 75xxxx plus bit match forces float entry
// - entry 642 drives stack pointer, reads, halts
// - first pass second operand, then first operand
// - high word to buffer, operand, register 11/10
// - copy high, pointer plus 2, read low
// - low word to 13, doubled, carry kept
// - high word doubled with saved carry in
// - exponent: high byte zero, bits 15:08 low
// - exponent high byte ones flag overflow/underflow
// - exponent to 15, zero sets zero bit
// - add constant 400 octal restoring hidden bit
// - zero exponent clears operand, flips pass flag
// - nonzero stores mantissa, clocks pass flag, steers
// - first pass end saves sign, next read
// - second pass uses registers 10, 12, 14
// - second pass moves zero flags, clears pass
module fou_unpack #(
   parameter int WORD_W = fou_pkg::WORD_W
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic fetch_done_i,
   input wire logic [5:0] branch_test_i,
   input wire logic [2:0] general_control_code_i,
   input wire logic [WORD_W-1:0] instr_i,
   input wire logic mem_reply_i,
   input wire logic [WORD_W-1:0] mem_data_i,
   input wire logic [fou_pkg::BUS_ADDR_W-1:0] reg_addr_i,
   input wire logic [WORD_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [WORD_W-1:0] reg_rdata_o,
   output logic [fou_pkg::CS_ADDR_W-1:0] cs_addr_o,
   output logic float_entry_o,
   output logic [WORD_W-1:0] bus_addr_o,
   output logic bus_read_o,
   output logic clock_halt_o,
   output logic busy_o,
   output logic done_o,
   output logic carry_status_bit_o,
   output logic zero_status_bit_o,
   output logic negative_status_bit_o,
   output logic other_exponent_zero_flag_o,
   output logic second_pass_flag_o
);
   fou_pkg::fou_state_t state;
   fou_pkg::fou_state_t next_state;
   logic [WORD_W-1:0] gpr [16];
   logic [WORD_W-1:0] bus_buffer_reg;
   logic [WORD_W-1:0] operand_reg;
   logic [WORD_W-1:0] shift_data_reg;
   logic [WORD_W-1:0] sign_holding_reg;
   logic [2:0] dst_idx;
   logic exp_zero;
   logic exp_ovf;
   logic exp_unf;
   logic reply_meta;
   logic reply_sync;
   logic reply_armed;
   logic [WORD_W-1:0] data_meta;
   logic [WORD_W-1:0] data_sync;

   // pin synchronisers; data settles before reply, so both take 2 flops
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reply_meta <= 1'b0;
         reply_sync <= 1'b0;
         data_meta <= fou_pkg::RESET_WORD;
         data_sync <= fou_pkg::RESET_WORD;
      end else begin
         reply_meta <= mem_reply_i;
         reply_sync <= reply_meta;
         data_meta <= mem_data_i;
         data_sync <= data_meta;
      end
   end

   // instruction decode
   wire ext_test = fetch_done_i && (branch_test_i == fou_pkg::BRANCH_TEST_EXT);
   wire float_opc = instr_i[15:9] == fou_pkg::FLOAT_OPC_HI;
   wire float_match = float_opc && (instr_i[8:5] == fou_pkg::FLOAT_OPC_SUB);
   wire start = ext_test && float_match && state == fou_pkg::FOU_IDLE;
   wire pass2 = second_pass_flag_o;
   // a reply counts only once armed, see reply_armed below
   wire reply_ok = reply_sync && reply_armed;
   wire read_start = state == fou_pkg::FOU_ENTRY || state == fou_pkg::FOU_PTR || state == fou_pkg::FOU_FIN;

   // odd slot on the first pass, even on the second
   wire [3:0] idx_high = pass2 ? fou_pkg::REG_HIGH - 4'h1 : fou_pkg::REG_HIGH;
   wire [3:0] idx_low = pass2 ? fou_pkg::REG_LOW - 4'h1 : fou_pkg::REG_LOW;
   wire [3:0] idx_exp = pass2 ? fou_pkg::REG_EXP_EVEN : fou_pkg::REG_EXP;
   wire [3:0] idx_ptr = {1'b0, dst_idx};
   wire [WORD_W-1:0] ptr_next = gpr[idx_ptr] + fou_pkg::PTR_STEP;

   // arithmetic paths
   wire [WORD_W:0] low_sum = {1'b0, operand_reg} + {1'b0, gpr[idx_low]};
   wire carry_in = carry_status_bit_o && (general_control_code_i == fou_pkg::GEN_CTL_CARRY_IN);
   wire [WORD_W-1:0] high_shift = {operand_reg[WORD_W-2:0], carry_in};
   wire [WORD_W-1:0] exp_word = {8'h00, operand_reg[15:8]};
   wire [WORD_W-1:0] mant_word = fou_pkg::HIDDEN_ONE + {8'h00, operand_reg[7:0]};
   wire exp_is_zero = exp_word == fou_pkg::RESET_WORD;

   // one register-file write per microstep
   wire st_wh = state == fou_pkg::FOU_WAIT_H;
   wire st_wl = state == fou_pkg::FOU_WAIT_L;
   wire fsm_we = (st_wh && reply_ok) || (st_wl && reply_ok) ||
                 state == fou_pkg::FOU_PTR || state == fou_pkg::FOU_SHL ||
                 state == fou_pkg::FOU_SHH || state == fou_pkg::FOU_SEP ||
                 state == fou_pkg::FOU_ZLO || state == fou_pkg::FOU_ZHI ||
                 state == fou_pkg::FOU_STORE || state == fou_pkg::FOU_FIN;
   wire [3:0] fsm_widx =
      (st_wh || state == fou_pkg::FOU_SHH || state == fou_pkg::FOU_ZHI ||
       state == fou_pkg::FOU_STORE) ? idx_high :
      (st_wl || state == fou_pkg::FOU_SHL || state == fou_pkg::FOU_ZLO) ? idx_low :
      (state == fou_pkg::FOU_SEP) ? idx_exp : idx_ptr;
   wire [WORD_W-1:0] fsm_wdata =
      (st_wh || st_wl) ? data_sync :
      (state == fou_pkg::FOU_SHL) ? low_sum[WORD_W-1:0] :
      (state == fou_pkg::FOU_SHH) ? high_shift :
      (state == fou_pkg::FOU_SEP) ? exp_word :
      (state == fou_pkg::FOU_ZLO || state == fou_pkg::FOU_ZHI) ? fou_pkg::RESET_WORD :
      (state == fou_pkg::FOU_STORE) ? operand_reg : ptr_next;
   wire bus_we = reg_wr_i && !reg_addr_i[4] && !fsm_we;

   // register bus read mux
   wire [7:0] status_bits = {exp_unf, exp_ovf, busy_o, second_pass_flag_o,
                             other_exponent_zero_flag_o, negative_status_bit_o,
                             zero_status_bit_o, carry_status_bit_o};
   wire [WORD_W-1:0] rd_mux =
      !reg_addr_i[4] ? gpr[reg_addr_i[3:0]] :
      (reg_addr_i == fou_pkg::ADDR_STATUS) ? {8'h00, status_bits} :
      (reg_addr_i == fou_pkg::ADDR_SIGN) ? sign_holding_reg : fou_pkg::RESET_WORD;

   // exponent high byte watch on software exponent arithmetic
   // ones arriving from the right mean overflow, from the left underflow
   wire exp_bus_wr = bus_we &&
      (reg_addr_i[3:0] == fou_pkg::REG_EXP || reg_addr_i[3:0] == fou_pkg::REG_EXP_EVEN);

   // next state
   always_comb begin
      next_state = state;
      case (state)
         fou_pkg::FOU_IDLE: begin
            if (start) begin
               next_state = fou_pkg::FOU_ENTRY;
            end
         end
         fou_pkg::FOU_ENTRY: next_state = fou_pkg::FOU_WAIT_H;
         fou_pkg::FOU_WAIT_H: begin
            if (reply_ok) begin
               next_state = fou_pkg::FOU_PTR;
            end
         end
         fou_pkg::FOU_PTR: next_state = fou_pkg::FOU_WAIT_L;
         fou_pkg::FOU_WAIT_L: begin
            if (reply_ok) begin
               next_state = fou_pkg::FOU_SHL;
            end
         end
         fou_pkg::FOU_SHL: next_state = fou_pkg::FOU_SHH;
         fou_pkg::FOU_SHH: next_state = fou_pkg::FOU_SEP;
         fou_pkg::FOU_SEP: next_state = fou_pkg::FOU_HID;
         fou_pkg::FOU_HID: next_state = exp_zero ? fou_pkg::FOU_ZLO : fou_pkg::FOU_STORE;
         fou_pkg::FOU_ZLO: next_state = fou_pkg::FOU_ZHI;
         fou_pkg::FOU_ZHI: next_state = pass2 ? fou_pkg::FOU_DONE : fou_pkg::FOU_FIN;
         fou_pkg::FOU_STORE: next_state = pass2 ? fou_pkg::FOU_DONE : fou_pkg::FOU_FIN;
         fou_pkg::FOU_FIN: next_state = fou_pkg::FOU_WAIT_H;
         fou_pkg::FOU_DONE: next_state = fou_pkg::FOU_IDLE;
         default: next_state = fou_pkg::FOU_IDLE;
      endcase
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state <= fou_pkg::FOU_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // general register file
   // a bus write in a sequence step that writes the file is dropped, not queued
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < 16; i++) begin
            gpr[i] <= fou_pkg::RESET_WORD;
         end
      end else if (fsm_we) begin
         gpr[fsm_widx] <= fsm_wdata;
      end else if (bus_we) begin
         gpr[reg_addr_i[3:0]] <= reg_wdata_i;
      end
   end

   // control store address
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cs_addr_o <= '0;
         float_entry_o <= 1'b0;
      end else begin
         float_entry_o <= start;
         if (start) begin
            cs_addr_o <= fou_pkg::CS_FLOAT_ENTRY;
         end else if (ext_test) begin
            cs_addr_o[fou_pkg::CS_EXT_BIT] <= 1'b1;
         end else if (fetch_done_i) begin
            cs_addr_o <= '0;
         end
      end
   end

   // a reply from the previous read can still stand when a new read starts;
   // it is trusted only after the synced reply has been seen low
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reply_armed <= 1'b0;
      end else if (read_start) begin
         reply_armed <= 1'b0;
      end else if ((st_wh || st_wl) && !reply_sync) begin
         reply_armed <= 1'b1;
      end
   end

   // memory read control and clock halt
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         bus_addr_o <= fou_pkg::RESET_WORD;
         bus_read_o <= 1'b0;
         clock_halt_o <= 1'b0;
         dst_idx <= 3'h0;
      end else begin
         bus_read_o <= 1'b0;
         if (start) begin
            dst_idx <= instr_i[2:0];
         end
         if (state == fou_pkg::FOU_ENTRY) begin
            bus_addr_o <= gpr[idx_ptr];
            bus_read_o <= 1'b1;
            clock_halt_o <= 1'b1;
         end else if (state == fou_pkg::FOU_PTR || state == fou_pkg::FOU_FIN) begin
            bus_addr_o <= ptr_next;
            bus_read_o <= 1'b1;
            clock_halt_o <= 1'b1;
         end else if ((st_wh || st_wl) && reply_ok) begin
            clock_halt_o <= 1'b0;
         end
      end
   end

   // datapath registers
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         bus_buffer_reg <= fou_pkg::RESET_WORD;
         operand_reg <= fou_pkg::RESET_WORD;
         shift_data_reg <= fou_pkg::RESET_WORD;
         sign_holding_reg <= fou_pkg::RESET_WORD;
      end else begin
         case (state)
            fou_pkg::FOU_WAIT_H: begin
               if (reply_ok) begin
                  bus_buffer_reg <= data_sync;
                  operand_reg <= data_sync;
               end
            end
            fou_pkg::FOU_PTR: shift_data_reg <= bus_buffer_reg;
            fou_pkg::FOU_WAIT_L: begin
               if (reply_ok) begin
                  operand_reg <= data_sync;
               end
            end
            fou_pkg::FOU_SHL: operand_reg <= gpr[idx_high];
            fou_pkg::FOU_SHH: operand_reg <= high_shift;
            fou_pkg::FOU_HID: operand_reg <= mant_word;
            fou_pkg::FOU_ZLO: begin
               // the buffer copy goes too, so a zero operand keeps no sign
               bus_buffer_reg <= fou_pkg::RESET_WORD;
               operand_reg <= fou_pkg::RESET_WORD;
            end
            fou_pkg::FOU_FIN: sign_holding_reg <= bus_buffer_reg;
            default: begin
            end
         endcase
      end
   end

   // status bits and pass flag
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         carry_status_bit_o <= 1'b0;
         zero_status_bit_o <= 1'b0;
         negative_status_bit_o <= 1'b0;
         other_exponent_zero_flag_o <= 1'b0;
         second_pass_flag_o <= 1'b0;
         exp_zero <= 1'b0;
      end else begin
         case (state)
            fou_pkg::FOU_SHL: carry_status_bit_o <= low_sum[WORD_W];
            fou_pkg::FOU_SEP: begin
               exp_zero <= exp_is_zero;
               zero_status_bit_o <= exp_is_zero;
               if (pass2) begin
                  other_exponent_zero_flag_o <= zero_status_bit_o;
               end
            end
            fou_pkg::FOU_ZHI: second_pass_flag_o <= !second_pass_flag_o;
            fou_pkg::FOU_STORE: second_pass_flag_o <= !second_pass_flag_o;
            fou_pkg::FOU_FIN: negative_status_bit_o <= bus_buffer_reg[WORD_W-1];
            default: begin
            end
         endcase
      end
   end

   // exponent range watch, busy, done and register bus read data
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         exp_ovf <= 1'b0;
         exp_unf <= 1'b0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         reg_rdata_o <= fou_pkg::RESET_WORD;
      end else begin
         if (state == fou_pkg::FOU_SEP) begin
            exp_ovf <= 1'b0;
            exp_unf <= 1'b0;
         end else if (exp_bus_wr) begin
            exp_ovf <= reg_wdata_i[8] && !reg_wdata_i[15];
            exp_unf <= reg_wdata_i[15];
         end
         busy_o <= next_state != fou_pkg::FOU_IDLE;
         done_o <= state == fou_pkg::FOU_DONE;
         reg_rdata_o <= reg_rd_i ? rd_mux : fou_pkg::RESET_WORD;
      end
   end
endmodule : fou_unpack

/* File: verilog/fou_pkg.sv */
// fou_pkg: constants for the floating operand fetch and unpack block
// assumes a 16-bit word, a 16-entry general register file, 40 MHz clock
package fou_pkg;
   localparam int WORD_W = 16;
   localparam int REG_IDX_W = 4;
   localparam int BUS_ADDR_W = 5;
   localparam int CS_ADDR_W = 9;
   // control store and branch test codes (octal figures)
   localparam logic [5:0] BRANCH_TEST_EXT = 6'h1F;          // 37 octal
   localparam int CS_EXT_BIT = 8;
   localparam logic [CS_ADDR_W-1:0] CS_FLOAT_ENTRY = 9'h1A2; // 642 octal
   localparam logic [2:0] GEN_CTL_CARRY_IN = 3'h4;           // carry-in enable code
   // opcode 75xxxx octal: bit 15 = 0, bits 14:12 = 7, bits 11:9 = 5
   localparam logic [6:0] FLOAT_OPC_HI = 7'h3D;
   localparam logic [3:0] FLOAT_OPC_SUB = 4'h0;              // bits 8:5
   // odd register slots of the first pass; the second pass uses slot - 1
   localparam logic [REG_IDX_W-1:0] REG_HIGH = 4'hB;         // 11
   localparam logic [REG_IDX_W-1:0] REG_LOW = 4'hD;          // 13
   localparam logic [REG_IDX_W-1:0] REG_EXP = 4'hF;          // 15
   localparam logic [REG_IDX_W-1:0] REG_EXP_EVEN = 4'hE;     // 14
   localparam logic [WORD_W-1:0] PTR_STEP = 16'h0002;
   localparam logic [WORD_W-1:0] HIDDEN_ONE = 16'h0100;      // 400 octal
   // register bus map: 0..15 general registers, then status
   localparam logic [BUS_ADDR_W-1:0] ADDR_STATUS = 5'h10;
   localparam logic [BUS_ADDR_W-1:0] ADDR_SIGN = 5'h11;
   localparam int ST_C = 0;
   localparam int ST_Z = 1;
   localparam int ST_N = 2;
   localparam int ST_OTHER_Z = 3;
   localparam int ST_PASS2 = 4;
   localparam int ST_BUSY = 5;
   localparam int ST_EXP_OVF = 6;
   localparam int ST_EXP_UNF = 7;
   localparam logic [WORD_W-1:0] RESET_WORD = 16'h0000;
   typedef enum logic [13:0] {
      FOU_IDLE   = 14'b00000000000001,
      FOU_ENTRY  = 14'b00000000000010,
      FOU_WAIT_H = 14'b00000000000100,
      FOU_PTR    = 14'b00000000001000,
      FOU_WAIT_L = 14'b00000000010000,
      FOU_SHL    = 14'b00000000100000,
      FOU_SHH    = 14'b00000001000000,
      FOU_SEP    = 14'b00000010000000,
      FOU_HID    = 14'b00000100000000,
      FOU_ZLO    = 14'b00001000000000,
      FOU_ZHI    = 14'b00010000000000,
      FOU_STORE  = 14'b00100000000000,
      FOU_FIN    = 14'b01000000000000,
      FOU_DONE   = 14'b10000000000000
   } fou_state_t;
endpackage : fou_pkg

/* File: dv/fou_unpack_properties.sv */
// fou_unpack_properties: port-level checks of the float fetch block
// assumes bind onto fou_unpack, one clock, async active-high reset
`timescale 1ns/1ps
module fou_unpack_properties #(
   parameter int WORD_W = fou_pkg::WORD_W
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic fetch_done_i,
   input wire logic [5:0] branch_test_i,
   input wire logic [WORD_W-1:0] instr_i,
   input wire logic mem_reply_i,
   input wire logic [fou_pkg::CS_ADDR_W-1:0] cs_addr_o,
   input wire logic float_entry_o,
   input wire logic bus_read_o,
   input wire logic clock_halt_o,
   input wire logic busy_o,
   input wire logic done_o,
   input wire logic second_pass_flag_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   wire ext_w = fetch_done_i && branch_test_i == fou_pkg::BRANCH_TEST_EXT;
   wire flt_w = instr_i[15:9] == fou_pkg::FLOAT_OPC_HI && instr_i[8:5] == fou_pkg::FLOAT_OPC_SUB;
   sequence s_start;
      ext_w && flt_w && !busy_o;
   endsequence
   sequence s_read;
      bus_read_o ##1 (clock_halt_o && !bus_read_o);
   endsequence
   a_entry_addr: assert property (s_start |=> float_entry_o && cs_addr_o == fou_pkg::CS_FLOAT_ENTRY)
      else $error("float entry not taken");
   a_ext_bit: assert property (ext_w && !busy_o |=> cs_addr_o[fou_pkg::CS_EXT_BIT])
      else $error("extended area bit not set");
   a_plain_fetch: assert property (fetch_done_i && !ext_w && !busy_o |=> !cs_addr_o[fou_pkg::CS_EXT_BIT])
      else $error("extended area bit set without test");
   a_entry_read: assert property (float_entry_o |=> s_read)
      else $error("no read after float entry");
   a_read_halt: assert property (bus_read_o |-> clock_halt_o && busy_o)
      else $error("read start without halt");
   a_halt_hold: assert property (bus_read_o |=> clock_halt_o ##1 clock_halt_o ##1 clock_halt_o)
      else $error("clock resumed on a stale reply");
   a_halt_wait: assert property (clock_halt_o && !mem_reply_i |=> clock_halt_o)
      else $error("clock resumed before reply");
   a_halt_bound: assert property ($rose(mem_reply_i) |-> ##[1:5] !clock_halt_o)
      else $error("clock not resumed after reply");
   a_done_end: assert property (done_o |=> !done_o && !second_pass_flag_o)
      else $error("done not a pulse or pass flag left set");
   a_idle_pass: assert property (!busy_o |-> !second_pass_flag_o)
      else $error("pass flag set while idle");
endmodule : fou_unpack_properties
bind fou_unpack fou_unpack_properties #(.WORD_W(WORD_W)) u_props (.clock_i, .sys_rst_i, .fetch_done_i,
   .branch_test_i, .instr_i, .mem_reply_i, .cs_addr_o, .float_entry_o, .bus_read_o, .clock_halt_o,
   .busy_o, .done_o, .second_pass_flag_o);

/* File: dv/fou_mem_model.sv */
// fou_mem_model: word memory answering read pulses after a set delay
// assumes byte pointers into 16 words; reply held until the next read
`timescale 1ns/1ps
module fou_mem_model (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic bus_read_i,
   input wire logic [15:0] bus_addr_i,
   input wire logic [3:0] delay_i,
   output logic reply_o,
   output logic [15:0] data_o
);
   logic [15:0] mem [0:15];
   logic [3:0] idx;
   logic [3:0] cnt;
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reply_o <= 1'b0;
         data_o <= 16'h5A5A;
         cnt <= 4'h0;
         idx <= 4'h0;
      end else if (bus_read_i) begin
         reply_o <= 1'b0;
         data_o <= ~data_o;
         cnt <= delay_i;
         idx <= bus_addr_i[4:1];
      end else if (cnt > 4'h1) begin
         cnt <= cnt - 4'h1;
         data_o <= ~data_o;
      end else if (cnt == 4'h1) begin
         cnt <= 4'h0;
         reply_o <= 1'b1;
         data_o <= mem[idx];
      end
   end
endmodule : fou_mem_model

/* File: dv/tb.sv */
// tb: self-checking bench for the float operand fetch and unpack block
// assumes fou_pkg, fou_unpack, fou_mem_model and the bound checker
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
   logic clock_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic fetch_done_i = 1'b0;
   logic [5:0] branch_test_i = 6'h00;
   logic [15:0] instr_i = 16'h0000;
   logic [4:0] reg_addr_i = 5'h00;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [3:0] dly = 4'h1;
   logic [2:0] gcc = fou_pkg::GEN_CTL_CARRY_IN;
   logic mem_reply, bus_read, halt, busy, done, cflag, zflag, nflag, ozflag, pflag, fentry;
   logic [15:0] rdata, baddr, mdata;
   logic [8:0] cs_addr;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   fou_unpack u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .fetch_done_i(fetch_done_i),
      .branch_test_i(branch_test_i), .general_control_code_i(gcc), .instr_i(instr_i),
      .mem_reply_i(mem_reply), .mem_data_i(mdata), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata), .cs_addr_o(cs_addr), .float_entry_o(fentry),
      .bus_addr_o(baddr), .bus_read_o(bus_read), .clock_halt_o(halt), .busy_o(busy), .done_o(done),
      .carry_status_bit_o(cflag), .zero_status_bit_o(zflag), .negative_status_bit_o(nflag),
      .other_exponent_zero_flag_o(ozflag), .second_pass_flag_o(pflag));
   fou_mem_model u_mem (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .bus_read_i(bus_read), .bus_addr_i(baddr),
      .delay_i(dly), .reply_o(mem_reply), .data_o(mdata));
   initial begin
      forever #12.5 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         final_report();
      end
   end
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [15:0] v);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1;
      v = rdata;
   endtask : rd
   task automatic start(input logic [5:0] bt, input logic [15:0] ins);
      @(posedge clock_i);
      fetch_done_i <= 1'b1;
      branch_test_i <= bt;
      instr_i <= ins;
      @(posedge clock_i);
      fetch_done_i <= 1'b0;
      #1;
   endtask : start
   // expected unpack of one operand: 32-bit shift, exponent split, hidden one
   function automatic void unp(input logic [15:0] h, l, output logic [15:0] hi, lo, ex);
      logic [15:0] h2;
      h2 = {h[14:0], l[15] && gcc == fou_pkg::GEN_CTL_CARRY_IN};
      ex = {8'h00, h2[15:8]};
      hi = (ex == 16'h0000) ? 16'h0000 : {8'h00, h2[7:0]} + fou_pkg::HIDDEN_ONE;
      lo = (ex == 16'h0000) ? 16'h0000 : {l[14:0], 1'b0};
   endfunction : unp
   task automatic run_op(input logic [15:0] p, hb, lb, ha, la, input logic [3:0] d);
      logic [15:0] e [10:15];
      logic [15:0] q [$];
      logic [15:0] v;
      logic zb, za, sb;
      int i;
      dly = d;
      u_mem.mem[p[4:1]] = hb;
      u_mem.mem[p[4:1] + 4'h1] = lb;
      u_mem.mem[p[4:1] + 4'h2] = ha;
      u_mem.mem[p[4:1] + 4'h3] = la;
      wr(5'h03, p);
      unp(hb, lb, e[11], e[13], e[15]);
      unp(ha, la, e[10], e[12], e[14]);
      zb = (e[15] == 16'h0000);
      za = (e[14] == 16'h0000);
      sb = hb[15] && !zb;
      start(6'h1F, 16'h7A03);
      `CHK({fentry, cs_addr}, {1'b1, fou_pkg::CS_FLOAT_ENTRY})
      for (i = 0; i < 400 && done !== 1'b1; i++) begin
         @(posedge clock_i);
         #1;
         if (bus_read === 1'b1) q.push_back(baddr);
      end
      `CHK(done, 1'b1)
      `CHK({q[0], q[1], q[2], q[3]}, {p, p + 16'h2, p + 16'h4, p + 16'h6})
      for (i = 10; i < 16; i++) begin
         rd(5'(i), v);
         `CHK(v, e[i])
      end
      rd(5'h03, v);
      `CHK(v, p + 16'h6)
      rd(fou_pkg::ADDR_STATUS, v);
      `CHK(v[7:1], {4'h0, zb, sb, za})
      rd(fou_pkg::ADDR_SIGN, v);
      `CHK(v[15], sb)
      `CHK({cflag, zflag, nflag, ozflag, pflag}, {la[15], za, sb, zb, 1'b0})
   endtask : run_op
   task automatic t_reset;
      `CHK({cs_addr, fentry, bus_read, halt, busy, done, cflag, zflag, nflag, ozflag, pflag}, 19'h0)
   endtask : t_reset
   task automatic t_decode;
      start(6'h1F, 16'h0A03);
      `CHK({fentry, cs_addr[8]}, 2'b01)
      start(6'h05, 16'h7A03);
      `CHK({fentry, cs_addr[8], busy}, 3'b000)
      start(6'h1F, 16'h7A23);
      `CHK({fentry, cs_addr[8], busy}, 3'b010)
   endtask : t_decode
   task automatic t_regbus;
      logic [15:0] v;
      wr(5'h0F, 16'h0100);
      rd(fou_pkg::ADDR_STATUS, v);
      `CHK(v[7:6], 2'b01)
      wr(5'h0F, 16'hFF00);
      rd(fou_pkg::ADDR_STATUS, v);
      `CHK(v[7:6], 2'b10)
      wr(fou_pkg::ADDR_STATUS, 16'h00FF);
      rd(fou_pkg::ADDR_STATUS, v);
      `CHK(v[5:0], 6'h00)
      rd(5'h12, v);
      `CHK(v, 16'h0000)
   endtask : t_regbus
   task automatic t_plain;
      run_op(16'h0008, 16'h40C9, 16'h8001, 16'hC120, 16'h1234, 4'h1);
   endtask : t_plain
   task automatic t_zero_b;
      run_op(16'h0004, 16'h807F, 16'hFFFF, 16'h4100, 16'h8000, 4'h6);
   endtask : t_zero_b
   task automatic t_zero_a;
      run_op(16'h0010, 16'hBF80, 16'h0000, 16'h0000, 16'h5555, 4'h3);
   endtask : t_zero_a
   task automatic t_no_carry;
      @(posedge clock_i);
      gcc <= 3'h0;
      run_op(16'h0002, 16'h40C9, 16'h8001, 16'hC1A0, 16'h9234, 4'h2);
      @(posedge clock_i);
      gcc <= fou_pkg::GEN_CTL_CARRY_IN;
   endtask : t_no_carry
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (4) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      @(posedge clock_i);
      #1;
      t_reset();
      t_decode();
      t_regbus();
      t_plain();
      t_zero_b();
      t_zero_a();
      t_no_carry();
      final_report();
   end
endmodule : tb
